/* File: src/trunk_card_pkg.sv */
package trunk_card_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Rates
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_MHZ;
  localparam int unsigned LINE_RATE_KBPS = 2048;
  localparam int unsigned DCH_RATE_KBPS  = 64;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM register map, byte addresses
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned BE_W    = DATA_W / 8;
  localparam int unsigned LANE_W  = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 4'h4;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 4'hC;

  ////////////////////////////////////////////////////////////////////////////
  // Field layouts
  typedef struct packed {
    logic       db_en;
    logic       dch_port;
    logic       rate_64k;
    logic [1:0] net_dis;
    logic [1:0] oos;
    logic [1:0] loop_en;
    logic       card_on;
  } ctrl_t;
  localparam int unsigned CTRL_W   = $bits(ctrl_t);
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  typedef struct packed {
    logic       link_chg;
    logic       hrdy_chg;
    logic [1:0] fea;
    logic [1:0] near_end_alarm_led;
  } int_t;
  localparam int unsigned INT_W = $bits(int_t);
  localparam logic [INT_W-1:0] INT_RST = 6'h00;

  typedef struct packed {
    logic       db_present;
    logic [1:0] remote_loopback_led;
    logic [1:0] fea;
    logic [1:0] near_end_alarm_led;
    logic       link_ready;
    logic       handler_ready;
    logic       mode_pri;
    logic       sw_en;
  } status_t;

  typedef struct packed {
    logic sig_loss;
    logic sync_loss;
    logic far_alarm_rx;
    logic loopback;
  } line_in_t;

  typedef struct packed {
    logic       sw_en;
    logic       mode_pri;
    logic       handler_ready;
    logic       db_present;
    line_in_t [1:0] line;
  } pins_t;
  localparam int unsigned PIN_W = $bits(pins_t);

  typedef struct packed {
    logic disabled;
    logic oos;
    logic near_end_alarm_led;
    logic fea;
    logic remote_loopback_led;
    logic far_alarm_tx;
    logic call_proc_en;
    logic link_ok;
  } port_led_t;
  localparam logic [$bits(port_led_t)-1:0] PORT_RST = 8'h80;

endpackage : trunk_card_pkg

/* File: src/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;
  sync_st_t s;
  sync_st_t next_s;

  // A bit moves only once stages two and three agree on it
  always_comb begin
    next_s    = s;
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign q_o = s.q;
endmodule : pin_sync

/* File: src/trunk_port_status.sv */
`timescale 1ns/100ps
module trunk_port_status (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  input  wire logic                      loop_en_i,
  input  wire logic                      sw_oos_i,
  input  wire trunk_card_pkg::line_in_t  line_i,
  output trunk_card_pkg::port_led_t      led_o
);
  trunk_card_pkg::port_led_t s;
  trunk_card_pkg::port_led_t next_s;
  logic                      alarm;

  always_comb begin
    alarm               = line_i.sig_loss | line_i.sync_loss;
    next_s              = s;
    next_s.disabled     = ~loop_en_i;
    next_s.oos          = sw_oos_i;
    next_s.near_end_alarm_led          = alarm;
    next_s.far_alarm_tx = alarm;
    next_s.fea          = line_i.far_alarm_rx;
    next_s.remote_loopback_led          = line_i.loopback;
    next_s.call_proc_en = loop_en_i & ~line_i.loopback;
    next_s.link_ok      = loop_en_i & ~sw_oos_i & ~alarm
                          & ~line_i.far_alarm_rx;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= trunk_card_pkg::PORT_RST;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign led_o = s;

  ////////////////////////////////////////////////////////////////////////////
  fartx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.far_alarm_tx == s.near_end_alarm_led) else $error("far alarm not sent with near alarm");
  fealed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> s.fea == $past(line_i.far_alarm_rx)) else $error("far alarm led lags");
  lbk_inhibit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.remote_loopback_led |-> !s.call_proc_en) else $error("calls run during loopback");
  dis_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !loop_en_i) |=> s.disabled) else $error("trunk disabled led dark");
  oos_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> s.oos == $past(sw_oos_i)) else $error("oos led wrong");
endmodule : trunk_port_status

/* File: src/trunk_card_status.sv */
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - Link ready only when rate, loop, alarms clean
// - Disabled switch: bus accesses get no answer
// - Net port led: switch off, unenabled, software
// - Trunk disabled led after reset or disable
// - One out-of-service led per trunk port
// - Signal or sync loss: near led, send far
// - Far-end alarm led follows remote report
// - Loopback lights led, stops call processing
// - Daughterboard lamp green, red or dark
// - Each recovered clock goes to two controllers
// - Strap picks digital-trunk or primary-rate mode
// - Trunk ports face a 2.048 Mbps line
module trunk_card_status (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  input  wire logic        card_enable_switch_i,
  input  wire logic        primary_rate_mode_i,
  input  wire logic        handler_ready_in_i,
  input  wire logic        dchan_daughterboard_present_i,
  input  wire logic [1:0]  sig_loss_i,
  input  wire logic [1:0]  sync_loss_i,
  input  wire logic [1:0]  far_alarm_rx_i,
  input  wire logic [1:0]  remote_loopback_i,
  input  wire logic [1:0]  recovered_clk_i,
  output logic             link_ready_out_o,
  output logic      [1:0]  far_alarm_tx_o,
  output logic      [1:0]  call_proc_en_o,
  output logic      [1:0]  net_port_disabled_led_o,
  output logic      [1:0]  trunk_disabled_led_o,
  output logic      [1:0]  oos_led_o,
  output logic      [1:0]  near_end_alarm_led_o,
  output logic      [1:0]  far_end_alarm_led_o,
  output logic      [1:0]  remote_loopback_led_o,
  output logic             dchan_daughterboard_green_o,
  output logic             dchan_daughterboard_red_o,
  output logic      [1:0]  clk_ref_ctl0_o,
  output logic      [1:0]  clk_ref_ctl1_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    trunk_card_pkg::ctrl_t     ctrl;
    logic [trunk_card_pkg::INT_W-1:0]  int_st;
    logic [trunk_card_pkg::INT_W-1:0]  int_mask;
    logic                      ack;
    logic [trunk_card_pkg::DATA_W-1:0] rdata;
    logic                      link_ready;
    logic                      hrdy_q;
    logic [1:0]                nea_q;
    logic [1:0]                fea_q;
    logic [1:0]                net_led;
    logic                      led_g;
    logic                      led_r;
  } card_st_t;

  card_st_t                      s;
  card_st_t                      next_s;
  trunk_card_pkg::pins_t         pins_raw;
  trunk_card_pkg::pins_t         pins;
  trunk_card_pkg::port_led_t     port [2];
  trunk_card_pkg::status_t       stat;
  trunk_card_pkg::int_t          ev;
  logic                          req;
  logic                          link_cond;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs
  always_comb begin
    pins_raw.sw_en         = card_enable_switch_i;
    pins_raw.mode_pri      = primary_rate_mode_i;
    pins_raw.handler_ready = handler_ready_in_i;
    pins_raw.db_present    = dchan_daughterboard_present_i;
    for (int i = 0; i < 2; i++) begin
      pins_raw.line[i].sig_loss     = sig_loss_i[i];
      pins_raw.line[i].sync_loss    = sync_loss_i[i];
      pins_raw.line[i].far_alarm_rx = far_alarm_rx_i[i];
      pins_raw.line[i].loopback     = remote_loopback_i[i];
    end
  end

  pin_sync #(
    .W (trunk_card_pkg::PIN_W)
  ) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pins_raw),
    .q_o   (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trunk ports, one instance each so neither can disturb the other
  for (genvar p = 0; p < 2; p++) begin : g_port
    trunk_port_status u_port (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .loop_en_i (s.ctrl.loop_en[p]),
      .sw_oos_i  (s.ctrl.oos[p]),
      .line_i    (pins.line[p]),
      .led_o     (port[p])
    );
    assign trunk_disabled_led_o[p] = port[p].disabled;
    assign oos_led_o[p]            = port[p].oos;
    assign near_end_alarm_led_o[p] = port[p].near_end_alarm_led;
    assign far_end_alarm_led_o[p]  = port[p].fea;
    assign remote_loopback_led_o[p] = port[p].remote_loopback_led;
    assign far_alarm_tx_o[p]       = port[p].far_alarm_tx;
    assign call_proc_en_o[p]       = port[p].call_proc_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status view and events
  always_comb begin
    link_cond = s.ctrl.rate_64k & pins.mode_pri
                & port[s.ctrl.dch_port].link_ok;
    stat.sw_en         = pins.sw_en;
    stat.mode_pri      = pins.mode_pri;
    stat.handler_ready = pins.handler_ready;
    stat.link_ready    = s.link_ready;
    stat.db_present    = pins.db_present;
    for (int i = 0; i < 2; i++) begin
      stat.near_end_alarm_led[i] = port[i].near_end_alarm_led;
      stat.fea[i] = port[i].fea;
      stat.remote_loopback_led[i] = port[i].remote_loopback_led;
      ev.near_end_alarm_led[i]   = port[i].near_end_alarm_led & ~s.nea_q[i];
      ev.fea[i]   = port[i].fea & ~s.fea_q[i];
    end
    ev.hrdy_chg = pins.handler_ready ^ s.hrdy_q;
    ev.link_chg = link_cond ^ s.link_ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    req    = avs_read_i | avs_write_i;
    // The bus stays stalled while the switch is off; the access is held, not lost
    next_s.ack = req & ~s.ack & pins.sw_en;
    if (req & ~s.ack & pins.sw_en & avs_read_i) begin
      case (avs_address_i)
        trunk_card_pkg::CTRL_OFS:     next_s.rdata = 32'(s.ctrl);
        trunk_card_pkg::STATUS_OFS:   next_s.rdata = 32'(stat);
        trunk_card_pkg::INT_STAT_OFS: next_s.rdata = 32'(s.int_st);
        trunk_card_pkg::INT_MASK_OFS: next_s.rdata = 32'(s.int_mask);
        default:                      next_s.rdata = '0;
      endcase
    end
    if (s.ack & avs_write_i) begin
      case (avs_address_i)
        trunk_card_pkg::CTRL_OFS: begin
          for (int i = 0; i < trunk_card_pkg::CTRL_W; i++) begin
            if (avs_byteenable_i[i / trunk_card_pkg::LANE_W]) begin
              next_s.ctrl[i] = avs_writedata_i[i];
            end
          end
        end
        trunk_card_pkg::INT_MASK_OFS: begin
          for (int i = 0; i < trunk_card_pkg::INT_W; i++) begin
            if (avs_byteenable_i[i / trunk_card_pkg::LANE_W]) begin
              next_s.int_mask[i] = avs_writedata_i[i];
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (s.ack & avs_read_i & (avs_address_i == trunk_card_pkg::INT_STAT_OFS)) begin
      next_s.int_st = '0;
    end
    // Set after clear so an event in the clearing cycle survives
    next_s.int_st = next_s.int_st | ev;
    next_s.link_ready = link_cond;
    next_s.hrdy_q     = pins.handler_ready;
    for (int i = 0; i < 2; i++) begin
      next_s.nea_q[i]   = port[i].near_end_alarm_led;
      next_s.fea_q[i]   = port[i].fea;
      next_s.net_led[i] = ~pins.sw_en | ~s.ctrl.card_on
                          | s.ctrl.net_dis[i];
    end
    next_s.led_g = pins.db_present & s.ctrl.db_en;
    next_s.led_r = pins.db_present & ~s.ctrl.db_en;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.ctrl     <= trunk_card_pkg::CTRL_RST;
      s.int_st   <= trunk_card_pkg::INT_RST;
      s.int_mask <= trunk_card_pkg::INT_RST;
      s.net_led  <= 2'h3;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_waitrequest_o           = ~(s.ack & ce_i);
  assign avs_readdata_o              = s.rdata;
  assign irq_o                       = |(s.int_st & s.int_mask);
  assign link_ready_out_o            = s.link_ready;
  assign net_port_disabled_led_o     = s.net_led;
  assign dchan_daughterboard_green_o = s.led_g;
  assign dchan_daughterboard_red_o   = s.led_r;
  // Recovered line clocks pass straight through; a flop here would resample them
  assign clk_ref_ctl0_o              = recovered_clk_i;
  assign clk_ref_ctl1_o              = recovered_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wait_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && req && !s.ack && pins.sw_en) ##1 ce_i |-> !avs_waitrequest_o)
    else $error("access not answered in one cycle");
  no_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pins.sw_en && !s.ack) |=> avs_waitrequest_o)
    else $error("answered while switch off");
  net_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && (!pins.sw_en || !s.ctrl.card_on)) |=> net_port_disabled_led_o == 2'h3)
    else $error("net port led dark while disabled");
  link_ready_a: assert property (@(posedge clk_i) disable iff (rst_i)
    link_ready_out_o |-> $past(s.ctrl.rate_64k) && $past(pins.mode_pri))
    else $error("link ready without 64k primary-rate");
  link_alarm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && port[s.ctrl.dch_port].near_end_alarm_led) |=> !link_ready_out_o)
    else $error("link ready during near alarm");
  lamp_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(dchan_daughterboard_green_o && dchan_daughterboard_red_o))
    else $error("lamp green and red at once");
  lamp_dark_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !pins.db_present) |=> !dchan_daughterboard_green_o && !dchan_daughterboard_red_o)
    else $error("lamp lit with no daughterboard");
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.int_st & s.int_mask) != '0 |-> irq_o) else $error("irq missing");
  port_indep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && $stable(pins.line[1]) && $stable(s.ctrl.oos[1]) && $stable(s.ctrl.loop_en[1]))
    |=> $stable(port[1])) else $error("port 1 moved without cause");
endmodule : trunk_card_status

/* File: verification/dchan_handler_model.sv */
`timescale 1ns/100ps
module dchan_handler_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic want_i,
  input  wire logic slow_i,
  output logic      handler_ready_o
);
  logic [3:0] wait_cnt;

  // A slow handler takes thirteen cycles to come up; dropping want drops ready on the next edge
  always_ff @(posedge clk_i) begin
    if (rst_i || !want_i) begin
      wait_cnt        <= 4'h0;
      handler_ready_o <= 1'b0;
    end else if (wait_cnt == (slow_i ? 4'hC : 4'h1)) begin
      handler_ready_o <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : dchan_handler_model

/* File: verification/trunk_card_status_bench.sv */
`timescale 1ns/100ps
module trunk_card_status_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0, sw_i = 1'b0, pri_i = 1'b0;
  logic hrdy, want = 1'b0, slow = 1'b0, pres_i = 1'b0, link, wreq, irq, green, red;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] wd_i = 32'h0, rdat;
  logic [1:0] sig_i = 2'h0, syn_i = 2'h0, far_i = 2'h0, lbk_i = 2'h0, rclk_i = 2'h0;
  logic [1:0] fat, cpe, netl, disl, oosl, neal, feal, lbkl, ref0, ref1;
  int bad_count = 0;
  int checked = 0;
  trunk_card_pkg::ctrl_t c;
  trunk_card_pkg::status_t s;

  always #2 clk_i = ~clk_i;

  dchan_handler_model i_dchan_handler_model (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
    .slow_i(slow), .handler_ready_o(hrdy));

  trunk_card_status i_trunk_card_status (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .avs_address_i(adr_i), .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_byteenable_i(4'hF),
    .avs_writedata_i(wd_i), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq),
    .card_enable_switch_i(sw_i), .primary_rate_mode_i(pri_i), .handler_ready_in_i(hrdy),
    .dchan_daughterboard_present_i(pres_i), .sig_loss_i(sig_i), .sync_loss_i(syn_i),
    .far_alarm_rx_i(far_i), .remote_loopback_i(lbk_i), .recovered_clk_i(rclk_i),
    .link_ready_out_o(link), .far_alarm_tx_o(fat), .call_proc_en_o(cpe),
    .net_port_disabled_led_o(netl), .trunk_disabled_led_o(disl), .oos_led_o(oosl),
    .near_end_alarm_led_o(neal), .far_end_alarm_led_o(feal), .remote_loopback_led_o(lbkl),
    .dchan_daughterboard_green_o(green), .dchan_daughterboard_red_o(red),
    .clk_ref_ctl0_o(ref0), .clk_ref_ctl1_o(ref1));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_pins(input logic [1:0] got, input logic [1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : check_pins

  // Pins pass a synchroniser and filter, so allow twice its depth before looking
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask : settle

  // Holds the request until waitrequest is sampled low; that edge takes the read data
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    adr_i <= a;
    wd_i  <= d;
    wr_i  <= wr;
    rd_i  <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      $display("wrong value at %0t: bus answer never came", $time);
      complete_run();
    end
  endtask : bus

  task automatic set_ctrl();
    logic [31:0] q;
    bus(1'b1, trunk_card_pkg::CTRL_OFS, {22'h0, c}, q);
    settle();
  endtask : set_ctrl

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_and_switch();
    check_pins(netl, 2'b11, "net led while switch off");
    check_pins(disl, 2'b11, "trunk led after reset");
    check_pins({green, red}, 2'b00, "lamp dark");
    check_pins({link, irq}, 2'b00, "link and irq after reset");
    @(posedge clk_i);
    adr_i <= trunk_card_pkg::CTRL_OFS;
    rd_i  <= 1'b1;
    repeat (20) begin
      @(posedge clk_i);
      check_pins({1'b0, wreq}, 2'b01, "answer while switch off");
    end
    sw_i <= 1'b1;
    for (int n = 0; n < 50 && wreq !== 1'b0; n++) @(posedge clk_i);
    if (wreq !== 1'b0) begin
      bad_count++;
      $display("wrong value at %0t: no answer after switch on", $time);
      complete_run();
    end
    check_word(rdat, 32'h0, "ctrl after switch on");
    rd_i <= 1'b0;
    settle();
    check_pins(netl, 2'b11, "net led before card on");
    $display("test reset and switch done");
  endtask : test_reset_and_switch

  task automatic test_registers();
    logic [31:0] q;
    c = '0;
    c.card_on = 1'b1;
    c.loop_en = 2'b11;
    c.net_dis = 2'b01;
    c.db_en   = 1'b1;
    pres_i <= 1'b1;
    set_ctrl();
    bus(1'b0, trunk_card_pkg::CTRL_OFS, 32'h0, q);
    check_word(q, {22'h0, c}, "ctrl readback");
    check_pins(netl, 2'b01, "net led by software");
    check_pins(disl, 2'b00, "trunk led enabled");
    check_pins({green, red}, 2'b10, "lamp green");
    c.db_en = 1'b0;
    set_ctrl();
    check_pins({green, red}, 2'b01, "lamp red");
    c.loop_en = 2'b10;
    set_ctrl();
    check_pins(disl, 2'b01, "trunk 0 disabled");
    bus(1'b1, trunk_card_pkg::STATUS_OFS, 32'hFFFFFFFF, q);
    bus(1'b0, 4'h6, 32'h0, q);
    check_word(q, 32'h0, "unmapped read");
    pres_i <= 1'b0;
    settle();
    check_pins({green, red}, 2'b00, "lamp without board");
    $display("test registers done");
  endtask : test_registers

  task automatic test_link_ready();
    logic [31:0] q;
    trunk_card_pkg::ctrl_t base;
    base = '0;
    base.card_on = 1'b1;
    base.loop_en = 2'b11;
    base.rate_64k = 1'b1;
    c = base;
    pri_i <= 1'b1;
    want  <= 1'b1;
    slow  <= 1'b1;
    set_ctrl();
    settle();
    s = '0;
    {s.sw_en, s.mode_pri, s.handler_ready, s.link_ready} = 4'hF;
    bus(1'b0, trunk_card_pkg::STATUS_OFS, 32'h0, q);
    check_word(q, {21'h0, s}, "status with link up");
    for (int i = 0; i < 3; i++) begin
      c = base;
      if (i == 0) c.rate_64k = 1'b0;
      if (i == 1) c.loop_en[0] = 1'b0;
      if (i == 2) c.oos[0] = 1'b1;
      set_ctrl();
      check_pins({1'b0, link}, 2'b00, "link with ctrl fault");
    end
    c = base;
    set_ctrl();
    for (int i = 0; i < 3; i++) begin
      {sig_i, syn_i, far_i} <= 6'h1 << (2 * i);
      settle();
      check_pins({1'b0, link}, 2'b00, "link with line fault");
      {sig_i, syn_i, far_i} <= 6'h2 << (2 * i);
      settle();
      check_pins({1'b0, link}, 2'b01, "other port fault");
    end
    c.dch_port = 1'b1;
    set_ctrl();
    check_pins({1'b0, link}, 2'b00, "link on faulty port");
    {sig_i, syn_i, far_i} <= 6'h0;
    settle();
    check_pins({1'b0, link}, 2'b01, "link on clean port");
    pri_i <= 1'b0;
    settle();
    check_pins({1'b0, link}, 2'b00, "link in trunk mode");
    $display("test link ready done");
  endtask : test_link_ready

  task automatic test_alarms();
    logic [1:0] p;
    c = '0;
    c.card_on = 1'b1;
    c.loop_en = 2'b11;
    for (int j = 0; j < 2; j++) begin
      p = j ? 2'b01 : 2'b10;
      c.oos = p;
      sig_i <= j ? 2'b00 : p;
      syn_i <= j ? p : 2'b00;
      far_i <= p;
      lbk_i <= ~p;
      set_ctrl();
      check_pins(oosl, p, "oos led");
      check_pins(neal, p, "near alarm led");
      check_pins(fat, p, "far alarm sent");
      check_pins(feal, p, "far alarm led");
      check_pins(lbkl, ~p, "loopback led");
      check_pins(cpe, p, "call processing");
    end
    $display("test alarms done");
  endtask : test_alarms

  task automatic test_interrupts();
    logic [31:0] q;
    {sig_i, syn_i, far_i, lbk_i} <= 8'h00;
    c = '0;
    c.card_on = 1'b1;
    set_ctrl();
    bus(1'b0, trunk_card_pkg::INT_STAT_OFS, 32'h0, q);
    bus(1'b1, trunk_card_pkg::INT_MASK_OFS, 32'h00000001, q);
    sig_i <= 2'b10;
    settle();
    check_pins({1'b0, irq}, 2'b00, "masked event");
    bus(1'b0, trunk_card_pkg::INT_STAT_OFS, 32'h0, q);
    check_word(q, 32'h00000002, "masked status");
    syn_i <= 2'b01;
    settle();
    check_pins({1'b0, irq}, 2'b01, "unmasked event");
    bus(1'b0, trunk_card_pkg::INT_STAT_OFS, 32'h0, q);
    check_word(q, 32'h00000001, "unmasked status");
    repeat (2) @(posedge clk_i);
    check_pins({1'b0, irq}, 2'b00, "irq after clear");
    bus(1'b0, trunk_card_pkg::INT_MASK_OFS, 32'h0, q);
    check_word(q, 32'h00000001, "mask readback");
    $display("test interrupts done");
  endtask : test_interrupts

  task automatic test_clocks();
    for (int i = 0; i < 4; i++) begin
      rclk_i <= i[1:0];
      settle();
      check_pins(ref0, i[1:0], "clock to controller 0");
      check_pins(ref1, i[1:0], "clock to controller 1");
    end
    $display("test clocks done");
  endtask : test_clocks

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    test_reset_and_switch();
    test_registers();
    test_link_ready();
    test_alarms();
    test_interrupts();
    test_clocks();
    complete_run();
  end
endmodule : trunk_card_status_bench
